// ### design/rrs_pkg.sv
// Purpose: Shared constants and types for the rate reconfiguration sequencer
// Assumes: One 20 MHz clock; device-side helper logic answers each op
// Notes: Op codes and register offsets live here only
package rrs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned WAIT_TIMEOUT_NS = 10000000;
  localparam int unsigned WAIT_CYCLES = WAIT_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned SYNC_W = 5;
  // Software register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PKT_EXPECT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_BRACKET_BIT = 8;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_PASS_BIT = 1;
  localparam int unsigned STAT_FAIL_BIT = 2;
  localparam int unsigned STAT_STATE_LSB = 3;
  localparam int unsigned STAT_MODE_LSB = 8;
  localparam int unsigned STAT_WORD_LSB = 16;
  localparam logic [15:0] PKT_EXPECT_RST = 16'h0046;
  localparam logic CTRL_BRACKET_RST = 1'b1;
  // Device status word values
  localparam logic [3:0] READY_PLAIN = 4'h7;
  localparam logic [3:0] READY_STAMP = 4'hF;
  localparam logic [3:0] READY_CORE = 4'h1;
  localparam int unsigned RX_STAMP_BIT = 4;
  // Ops toward the transceiver
  localparam logic [19:0] ATTR_SERDES_EN = 20'h00001;
  localparam logic [19:0] ATTR_LOOPBACK = 20'h00008;
  localparam logic [19:0] ATTR_PHASE_ADJ = 20'h0000E;
  localparam logic [19:0] REG_EMIB_RESET = 20'h400E2;
  localparam logic [7:0] ARG_OFF = 8'h00;
  localparam logic [7:0] ARG_ON = 8'h01;
  localparam logic [7:0] ARG_RATE_10G = 8'h0A;
  localparam logic [7:0] ARG_RATE_25G = 8'h19;
  typedef enum logic [2:0] {
    OP_ATTR = 3'h0, OP_ANALOG_RST = 3'h1, OP_TX_RATIO = 3'h2,
    OP_RX_RATIO = 3'h3, OP_REG_REWRITE = 3'h4, OP_REF_SELECT = 3'h5,
    OP_PMA_CLK_SEL = 3'h6, OP_PMA_REG = 3'h7
  } rrs_op_t;
  typedef enum logic [3:0] {
    M_ETH10 = 4'h0, M_ETH25 = 4'h1, M_ETH25_FEC = 4'h2,
    M_ETH25_STAMP = 4'h3, M_CPRI24 = 4'h4, M_CPRI10 = 4'h5,
    M_CPRI9P8 = 4'h6, M_CPRI4P9 = 4'h7, M_CPRI2P4 = 4'h8
  } rrs_mode_t;
  localparam rrs_mode_t MODE_RST = M_ETH25_FEC;
  localparam logic [3:0] MODE_LAST = 4'h8;
  localparam logic [7:0] REF_156 = 8'h00;
  localparam logic [7:0] REF_184 = 8'h01;
  localparam logic [7:0] REF_153 = 8'h02;
endpackage : rrs_pkg

// ### design/rrs_sync.sv
// Purpose: Two-flop synchroniser for the device status word
// Assumes: Bits are slow levels; no multi-bit coherence needed
// Notes: First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module rrs_sync (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [rrs_pkg::SYNC_W-1:0] din,
  output logic [rrs_pkg::SYNC_W-1:0] dout
);
  import rrs_pkg::*;
  logic [SYNC_W-1:0] meta_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : rrs_sync
`default_nettype wire

// ### design/rrs_timer.sv
// Purpose: Wait guard counter that flags when a wait runs too long
// Assumes: restart pulses on every state entry
// Notes: Saturates at the limit so the flag stays up
`timescale 1ns/1ps
`default_nettype none
module rrs_timer #(
  parameter int unsigned LIMIT = rrs_pkg::WAIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic restart,
  output logic expired
);
  import rrs_pkg::*;
  logic [31:0] count_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= 32'h0;
    end else if (restart) begin
      count_q <= 32'h0;
    end else if (count_q < 32'(LIMIT)) begin
      count_q <= count_q + 32'h1;
    end
  end
  assign expired = (count_q >= 32'(LIMIT));
endmodule : rrs_timer
`default_nettype wire

// ### design/rrs_sequencer.sv
// Purpose: Steps an Ethernet/CPRI serial port from one mode to another
// Assumes: op_ack and packet counters come from logic on this clock
// Notes: status_word is a pin group and is synchronised first
// Function
// - Assert both soft resets before disabling the SERDES.
// - Disable and re-enable the SERDES with attribute code 0x0001.
// - Analog reset after SERDES disable and after reference switch.
// - Reprogram transmit bit/refclk ratio on 10G/25G change.
// - Reprogram receive ratio right after the transmit ratio.
// - Rewrite Ethernet, FEC and transceiver registers after ratio or reset.
// - Adjust recovered clock phase with code 0x000E before re-enable.
// - Enable SERDES loopback with code 0x0008 after re-enable.
// - Release both soft resets after loopback; Ethernet modes then wait for ready.
// - Non-stamping Ethernet modes wait for status word 0x7.
// - Clear stats, run generator, stop once all packets sent.
// - Ethernet modes pass only after the checker saw the expected packets; CPRI passes right after release.
// - 25G with and without FEC skip the ratio changes.
// - CPRI flow waits for status 0x1 before loopback.
// - Stamping modes wait for status word 0xF.
// - Keep sending packets until receive stamping bit 4 sets.
// - To 184.32 MHz: controller clock alternate, switch, back to primary.
// - Back to 156 MHz uses the same bracketing.
// - Controller clock bracketing may be turned off for simulation.
// - Low CPRI rates pulse EMIB reset via 0x400E2 before enable.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rrs_sequencer #(
  parameter int unsigned WAIT_LIMIT = rrs_pkg::WAIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [31:0] rd_data_q,
  output logic tx_soft_reset_n_q,
  output logic rx_soft_reset_n_q,
  output logic op_req_q,
  output rrs_pkg::rrs_op_t op_kind_q,
  output logic [19:0] op_code_q,
  output logic [7:0] op_arg_q,
  input wire logic op_ack,
  input wire logic [rrs_pkg::SYNC_W-1:0] status_word,
  output logic stat_clear_q,
  output logic gen_enable_q,
  input wire logic [15:0] tx_pkt_count,
  input wire logic [15:0] rx_pkt_count
);
  import rrs_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00000, S_ASSERT_RST = 5'b00001, S_SER_OFF = 5'b00011,
    S_CLK_ALT = 5'b00010, S_REF_SW = 5'b00110, S_CLK_PRI = 5'b00111,
    S_ANA_RST = 5'b00101, S_TX_RATIO = 5'b00100, S_RX_RATIO = 5'b01100,
    S_REG_WR = 5'b01101, S_PHASE = 5'b01111, S_EMIB_ON = 5'b01110,
    S_EMIB_OFF = 5'b01010, S_SER_ON = 5'b01011, S_WAIT_CORE = 5'b01001,
    S_LOOPBACK = 5'b01000, S_RELEASE = 5'b11000, S_WAIT_READY = 5'b11001,
    S_TRAIN = 5'b11011, S_CLR_STATS = 5'b11010, S_GEN_RUN = 5'b11110,
    S_GEN_STOP = 5'b11111, S_CHECK = 5'b11101, S_PASS = 5'b11100,
    S_FAIL = 5'b10100
  } rrs_state_t;

  function automatic logic [7:0] ref_of(input rrs_mode_t m);
    case (m)
      M_CPRI24, M_CPRI10: ref_of = REF_184;
      M_CPRI9P8, M_CPRI4P9, M_CPRI2P4: ref_of = REF_153;
      default: ref_of = REF_156;
    endcase
  endfunction : ref_of

  function automatic logic is_cpri(input rrs_mode_t m);
    is_cpri = (m >= M_CPRI24);
  endfunction : is_cpri

  // Ratio only differs between the 10G and 25G Ethernet families
  function automatic logic [7:0] rate_of(input rrs_mode_t m);
    rate_of = (m == M_ETH10) ? ARG_RATE_10G : ARG_RATE_25G;
  endfunction : rate_of

  rrs_state_t state_q;
  rrs_state_t last_state_q;
  rrs_mode_t cur_mode_q;
  rrs_mode_t tgt_mode_q;
  logic bracket_q;
  logic [15:0] pkt_expect_q;
  logic pass_q;
  logic fail_q;
  logic [SYNC_W-1:0] status_s;
  logic expired;
  logic ratio_chg;
  logic ref_chg;
  logic stamp_mode;
  logic start_ok;
  logic settled;
  logic timed_out;

  rrs_sync u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .din(status_word),
    .dout(status_s)
  );

  rrs_timer #(.LIMIT(WAIT_LIMIT)) u_timer (
    .clock(clock),
    .rst_b(rst_b),
    .restart(state_q != last_state_q),
    .expired(expired)
  );

  assign ratio_chg = !is_cpri(cur_mode_q) && !is_cpri(tgt_mode_q) &&
                     (rate_of(cur_mode_q) != rate_of(tgt_mode_q));
  assign ref_chg = (ref_of(cur_mode_q) != ref_of(tgt_mode_q));
  assign stamp_mode = (tgt_mode_q == M_ETH25_STAMP);
  // Not busy only once the verdict flag is up, so mode and flags agree
  assign settled = (state_q == S_IDLE) || pass_q || fail_q;
  assign start_ok = wr_strobe && (addr == ADDR_CTRL) &&
                    wr_data[CTRL_START_BIT] &&
                    (wr_data[CTRL_MODE_LSB +: 4] <= MODE_LAST) && settled;
  // A state's first cycle still sees the count left by the one before
  assign timed_out = expired && (state_q == last_state_q) &&
                     !(state_q inside {S_IDLE, S_PASS, S_FAIL});

  // Software registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tgt_mode_q <= MODE_RST;
      bracket_q <= CTRL_BRACKET_RST;
      pkt_expect_q <= PKT_EXPECT_RST;
    end else if (wr_strobe) begin
      if (addr == ADDR_CTRL && state_q inside {S_IDLE, S_PASS, S_FAIL}) begin
        bracket_q <= wr_data[CTRL_BRACKET_BIT];
        if (wr_data[CTRL_MODE_LSB +: 4] <= MODE_LAST) begin
          tgt_mode_q <= rrs_mode_t'(wr_data[CTRL_MODE_LSB +: 4]);
        end
      end
      if (addr == ADDR_PKT_EXPECT) begin
        pkt_expect_q <= wr_data[15:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q <= 32'h0;
    end else if (rd_strobe) begin
      case (addr)
        ADDR_CTRL: rd_data_q <= {23'h0, bracket_q, 3'h0, tgt_mode_q, 1'b0};
        ADDR_PKT_EXPECT: rd_data_q <= {16'h0, pkt_expect_q};
        ADDR_STATUS: rd_data_q <= {11'h0, status_s, 4'h0, cur_mode_q,
                                   state_q, fail_q, pass_q, !settled};
        default: rd_data_q <= 32'h0;
      endcase
    end else begin
      rd_data_q <= 32'h0;
    end
  end

  // Sequence and op handshake; an op state issues once, advances on ack
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      last_state_q <= S_IDLE;
      op_req_q <= 1'b0;
      op_kind_q <= OP_ATTR;
      op_code_q <= 20'h0;
      op_arg_q <= ARG_OFF;
    end else begin
      last_state_q <= state_q;
      if (start_ok) begin
        state_q <= S_ASSERT_RST;
      end else if (timed_out) begin
        state_q <= S_FAIL;
        op_req_q <= 1'b0;
      end else if (op_req_q) begin
        if (op_ack) begin
          op_req_q <= 1'b0;
          case (state_q)
            S_SER_OFF: state_q <= !ref_chg ? S_ANA_RST :
                                  bracket_q ? S_CLK_ALT : S_REF_SW;
            S_CLK_ALT: state_q <= S_REF_SW;
            S_REF_SW: state_q <= bracket_q ? S_CLK_PRI : S_ANA_RST;
            S_CLK_PRI: state_q <= S_ANA_RST;
            S_ANA_RST: state_q <= ratio_chg ? S_TX_RATIO : S_REG_WR;
            S_TX_RATIO: state_q <= S_RX_RATIO;
            S_RX_RATIO: state_q <= S_REG_WR;
            S_REG_WR: state_q <= S_PHASE;
            S_PHASE: state_q <= (tgt_mode_q >= M_CPRI9P8) ? S_EMIB_ON :
                                S_SER_ON;
            S_EMIB_ON: state_q <= S_EMIB_OFF;
            S_EMIB_OFF: state_q <= S_SER_ON;
            S_SER_ON: state_q <= is_cpri(tgt_mode_q) ? S_WAIT_CORE :
                                 S_LOOPBACK;
            S_LOOPBACK: state_q <= S_RELEASE;
            default: state_q <= S_FAIL;
          endcase
        end
      end else begin
        case (state_q)
          S_IDLE, S_PASS, S_FAIL: state_q <= state_q;
          S_ASSERT_RST: state_q <= S_SER_OFF;
          S_SER_OFF, S_SER_ON: begin
            op_req_q <= 1'b1;
            op_kind_q <= OP_ATTR;
            op_code_q <= ATTR_SERDES_EN;
            op_arg_q <= (state_q == S_SER_ON) ? ARG_ON : ARG_OFF;
          end
          S_CLK_ALT, S_CLK_PRI: begin
            op_req_q <= 1'b1;
            op_kind_q <= OP_PMA_CLK_SEL;
            op_code_q <= 20'h0;
            op_arg_q <= (state_q == S_CLK_ALT) ? ARG_ON : ARG_OFF;
          end
          S_REF_SW: begin
            op_req_q <= 1'b1;
            op_kind_q <= OP_REF_SELECT;
            op_code_q <= 20'h0;
            op_arg_q <= ref_of(tgt_mode_q);
          end
          S_ANA_RST, S_REG_WR: begin
            op_req_q <= 1'b1;
            op_kind_q <= (state_q == S_ANA_RST) ? OP_ANALOG_RST :
                         OP_REG_REWRITE;
            op_code_q <= 20'h0;
            op_arg_q <= {4'h0, tgt_mode_q};
          end
          S_TX_RATIO, S_RX_RATIO: begin
            op_req_q <= 1'b1;
            op_kind_q <= (state_q == S_TX_RATIO) ? OP_TX_RATIO :
                         OP_RX_RATIO;
            op_code_q <= 20'h0;
            op_arg_q <= rate_of(tgt_mode_q);
          end
          S_PHASE, S_LOOPBACK: begin
            op_req_q <= 1'b1;
            op_kind_q <= OP_ATTR;
            op_code_q <= (state_q == S_PHASE) ? ATTR_PHASE_ADJ :
                         ATTR_LOOPBACK;
            op_arg_q <= ARG_ON;
          end
          S_EMIB_ON, S_EMIB_OFF: begin
            op_req_q <= 1'b1;
            op_kind_q <= OP_PMA_REG;
            op_code_q <= REG_EMIB_RESET;
            op_arg_q <= (state_q == S_EMIB_ON) ? ARG_ON : ARG_OFF;
          end
          S_WAIT_CORE: if (status_s[3:0] == READY_CORE) begin
            state_q <= S_LOOPBACK;
          end
          S_RELEASE: state_q <= is_cpri(tgt_mode_q) ? S_PASS : S_WAIT_READY;
          S_WAIT_READY: begin
            if (stamp_mode && status_s[3:0] == READY_STAMP) begin
              state_q <= S_TRAIN;
            end else if (!stamp_mode && status_s[3:0] == READY_PLAIN) begin
              state_q <= S_CLR_STATS;
            end
          end
          S_TRAIN: if (status_s[RX_STAMP_BIT]) begin
            state_q <= S_CLR_STATS;
          end
          S_CLR_STATS: state_q <= S_GEN_RUN;
          // Counts seen while the clear is still out are stale
          S_GEN_RUN: if (!stat_clear_q && tx_pkt_count >= pkt_expect_q) begin
            state_q <= S_GEN_STOP;
          end
          S_GEN_STOP: state_q <= S_CHECK;
          S_CHECK: if (rx_pkt_count >= pkt_expect_q) begin
            state_q <= S_PASS;
          end
          default: state_q <= S_FAIL;
        endcase
      end
    end
  end

  // Mode only moves on success, so a failed step can be retried as-is
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cur_mode_q <= MODE_RST;
      pass_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (start_ok) begin
      pass_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (state_q == S_PASS && last_state_q != S_PASS) begin
      cur_mode_q <= tgt_mode_q;
      pass_q <= 1'b1;
    end else if (state_q == S_FAIL) begin
      fail_q <= 1'b1;
    end
  end

  // Port held in reset from power-up until the first step reaches S_RELEASE
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_soft_reset_n_q <= 1'b0;
      rx_soft_reset_n_q <= 1'b0;
    end else if (state_q == S_ASSERT_RST) begin
      tx_soft_reset_n_q <= 1'b0;
      rx_soft_reset_n_q <= 1'b0;
    end else if (state_q == S_RELEASE) begin
      tx_soft_reset_n_q <= 1'b1;
      rx_soft_reset_n_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gen_enable_q <= 1'b0;
      stat_clear_q <= 1'b0;
    end else begin
      stat_clear_q <= (state_q == S_CLR_STATS);
      gen_enable_q <= (state_q == S_TRAIN || state_q == S_GEN_RUN);
    end
  end

  sequence s_loop_acked;
    op_req_q && op_code_q == ATTR_LOOPBACK && op_ack;
  endsequence

  AST_RST_BEFORE_OFF: assert property (@(posedge clock) disable iff (!rst_b)
    (op_req_q && op_code_q == ATTR_SERDES_EN && op_arg_q == ARG_OFF)
    |-> !tx_soft_reset_n_q && !rx_soft_reset_n_q)
    else $error("SERDES disabled while port out of reset");
  AST_SERDES_CODE: assert property (@(posedge clock) disable iff (!rst_b)
    (op_req_q && state_q inside {S_SER_OFF, S_SER_ON})
    |-> op_kind_q == OP_ATTR && op_code_q == 20'h00001)
    else $error("SERDES enable op carries wrong code");
  AST_ANA_BEFORE_REG: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(state_q == S_REG_WR)
    |-> $past(state_q) inside {S_ANA_RST, S_RX_RATIO})
    else $error("Register rewrite not preceded by analog reset");
  AST_RX_AFTER_TX: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(state_q == S_RX_RATIO) |-> $past(state_q) == S_TX_RATIO)
    else $error("Receive ratio not right after transmit ratio");
  AST_NO_RATIO_FEC: assert property (@(posedge clock) disable iff (!rst_b)
    state_q == S_TX_RATIO |-> rate_of(cur_mode_q) != rate_of(tgt_mode_q))
    else $error("Ratio changed without a rate change");
  AST_PHASE_CODE: assert property (@(posedge clock) disable iff (!rst_b)
    (op_req_q && state_q == S_PHASE) |-> op_code_q == 20'h0000E)
    else $error("Phase adjust uses wrong code");
  AST_RELEASE_AFTER_LOOP: assert property (@(posedge clock) disable iff (!rst_b)
    s_loop_acked |-> ##1 state_q == S_RELEASE ##1 tx_soft_reset_n_q)
    else $error("Resets not released after loopback");
  AST_READY_VALUE: assert property (@(posedge clock) disable iff (!rst_b)
    (state_q == S_WAIT_READY && !expired && !stamp_mode && !start_ok)
    ##1 state_q == S_CLR_STATS |-> $past(status_s[3:0]) == 4'h7)
    else $error("Left ready wait without status 0x7");
  AST_GEN_STOP: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(gen_enable_q) && $past(state_q) == S_GEN_STOP &&
    $past(state_q, 2) == S_GEN_RUN
    |-> $past(tx_pkt_count, 2) >= pkt_expect_q)
    else $error("Generator stopped before all packets sent");
  AST_PASS_COUNT: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(state_q == S_PASS) && $past(state_q) == S_CHECK
    |-> $past(rx_pkt_count) >= pkt_expect_q)
    else $error("Passed without expected packets");
  AST_TIMEOUT: assert property (@(posedge clock) disable iff (!rst_b)
    (timed_out && !start_ok) |=> state_q == S_FAIL)
    else $error("Timed-out wait did not fail");
endmodule : rrs_sequencer
`default_nettype wire

// ### test/rrs_dev_model.sv
// Purpose: Device-side model of the serial port behind the op link
// Assumes: Reg rewrite op carries the target mode in its argument
// Notes: Logs every op it takes, with both soft reset levels
`timescale 1ns/1ps
`default_nettype none
module rrs_dev_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic tx_rst_n,
  input wire logic rx_rst_n,
  input wire logic req,
  input wire rrs_pkg::rrs_op_t kind,
  input wire logic [19:0] code,
  input wire logic [7:0] arg,
  input wire logic [3:0] dly,
  input wire logic mute,
  input wire logic clr,
  input wire logic gen,
  output logic ack,
  output logic [4:0] stat,
  output logic [15:0] tx_cnt,
  output logic [15:0] rx_cnt
);
  import rrs_pkg::*;
  logic [32:0] log_q[$];
  logic [3:0] wait_q;
  logic ser_q;
  logic loop_q;
  logic stamp_q;
  logic [7:0] train_q;
  logic up;
  // Lock needs loopback and both resets gone; core ready alone before
  assign up = ser_q && loop_q && tx_rst_n && rx_rst_n;
  assign stat[0] = ser_q;
  assign stat[1] = up;
  assign stat[2] = up;
  assign stat[3] = up && stamp_q;
  assign stat[4] = stat[3] && train_q >= 8'h08;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'h0;
      wait_q <= 4'h0;
      ser_q <= 1'h0;
      loop_q <= 1'h0;
      stamp_q <= 1'h0;
    end else begin
      ack <= 1'h0;
      // Slow answers stretch by dly cycles; mute never answers
      if (req && !ack && !mute) begin
        if (wait_q < dly) begin
          wait_q <= wait_q + 4'h1;
        end else begin
          ack <= 1'h1;
          wait_q <= 4'h0;
          log_q.push_back({tx_rst_n, rx_rst_n, kind, code, arg});
          if (kind == OP_ATTR && code == ATTR_SERDES_EN) ser_q <= arg[0];
          if (kind == OP_ATTR && code == ATTR_LOOPBACK) loop_q <= arg[0];
          if (kind == OP_REG_REWRITE) stamp_q <= arg[3:0] == M_ETH25_STAMP;
        end
      end
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_cnt <= 16'h0000;
      rx_cnt <= 16'h0000;
      train_q <= 8'h00;
    end else begin
      if (clr) begin
        tx_cnt <= 16'h0000;
        rx_cnt <= 16'h0000;
      end else begin
        if (gen) tx_cnt <= tx_cnt + 16'h0001;
        if (up && rx_cnt < tx_cnt) rx_cnt <= rx_cnt + 16'h0001;
      end
      if (!tx_rst_n) train_q <= 8'h00;
      else if (gen && train_q != 8'hFF) train_q <= train_q + 8'h01;
    end
  end
endmodule : rrs_dev_model
`default_nettype wire

// ### test/test_rrs_sequencer.sv
// Purpose: Self-checking bench for the rate reconfiguration sequencer
// Assumes: Device model answers ops and tracks link status
// Notes: Table rows walk every mode; odd cases follow the loop
`timescale 1ns/1ps
`default_nettype none
module test_rrs_sequencer;
  import rrs_pkg::*;
  typedef struct packed {
    rrs_mode_t to;
    logic br;
    logic [3:0] dly;
  } rrs_row_t;
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_strobe = 1'h0;
  logic rd_strobe = 1'h0;
  logic mute = 1'h0;
  logic [3:0] dly = 4'h0;
  logic [31:0] rd_data_q, d;
  logic tx_n, rx_n, req, ack, clr, gen;
  rrs_op_t kind;
  logic [19:0] code;
  logic [7:0] arg;
  logic [4:0] stat;
  logic [15:0] tx_cnt, rx_cnt;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [33:0] exp_q[$];
  rrs_mode_t cur = MODE_RST;
  rrs_row_t rows[13] = '{'{M_ETH25, 1'h1, 4'h0}, '{M_ETH10, 1'h1, 4'h2},
    '{M_ETH25_STAMP, 1'h1, 4'h0}, '{M_CPRI24, 1'h1, 4'h1},
    '{M_ETH25_FEC, 1'h1, 4'h0}, '{M_CPRI9P8, 1'h0, 4'h3},
    '{M_ETH25_FEC, 1'h0, 4'h0}, '{M_CPRI10, 1'h1, 4'h0},
    '{M_ETH25_FEC, 1'h1, 4'h0}, '{M_CPRI4P9, 1'h1, 4'h0},
    '{M_ETH25_FEC, 1'h1, 4'h2}, '{M_CPRI2P4, 1'h0, 4'h0},
    '{M_ETH25_FEC, 1'h1, 4'h0}};
  rrs_sequencer #(.WAIT_LIMIT(64)) u_rrs_sequencer (.clock(clock),
    .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data_q(rd_data_q), .tx_soft_reset_n_q(tx_n),
    .rx_soft_reset_n_q(rx_n), .op_req_q(req), .op_kind_q(kind),
    .op_code_q(code), .op_arg_q(arg), .op_ack(ack), .status_word(stat),
    .stat_clear_q(clr), .gen_enable_q(gen), .tx_pkt_count(tx_cnt),
    .rx_pkt_count(rx_cnt));
  rrs_dev_model u_rrs_dev_model (.clock(clock), .rst_b(rst_b),
    .tx_rst_n(tx_n), .rx_rst_n(rx_n), .req(req), .kind(kind), .code(code),
    .arg(arg), .dly(dly), .mute(mute), .clr(clr), .gen(gen), .ack(ack),
    .stat(stat), .tx_cnt(tx_cnt), .rx_cnt(rx_cnt));
  task automatic conclude();
    $display("Compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a;
    wr_data <= v;
    wr_strobe <= 1'h1;
    @(posedge clock);
    wr_strobe <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd_strobe <= 1'h1;
    @(posedge clock);
    rd_strobe <= 1'h0;
    #1 v = rd_data_q;
  endtask : rd
  function automatic void push(rrs_op_t k, logic [19:0] c, logic [7:0] a,
    logic care);
    exp_q.push_back({care, 2'h0, k, c, a});
  endfunction : push
  function automatic logic [7:0] ref_of(input rrs_mode_t m);
    if (m <= M_ETH25_STAMP) return REF_156;
    if (m <= M_CPRI10) return REF_184;
    return REF_153;
  endfunction : ref_of
  function automatic void build(rrs_mode_t f, rrs_mode_t t, logic br);
    exp_q.delete();
    push(OP_ATTR, ATTR_SERDES_EN, ARG_OFF, 1'h1);
    if (ref_of(f) != ref_of(t)) begin
      if (br) push(OP_PMA_CLK_SEL, 20'h0, ARG_ON, 1'h1);
      push(OP_REF_SELECT, 20'h0, ref_of(t), 1'h1);
      if (br) push(OP_PMA_CLK_SEL, 20'h0, ARG_OFF, 1'h1);
    end
    push(OP_ANALOG_RST, 20'h0, 8'h00, 1'h0);
    // Ratios only when crossing between 10G and a 25G flavour
    if (f <= M_ETH25_STAMP && t <= M_ETH25_STAMP
        && (f == M_ETH10) != (t == M_ETH10)) begin
      push(OP_TX_RATIO, 20'h0, t == M_ETH10 ? ARG_RATE_10G : ARG_RATE_25G, 1);
      push(OP_RX_RATIO, 20'h0, t == M_ETH10 ? ARG_RATE_10G : ARG_RATE_25G, 1);
    end
    push(OP_REG_REWRITE, 20'h0, {4'h0, t}, 1'h1);
    push(OP_ATTR, ATTR_PHASE_ADJ, 8'h00, 1'h0);
    if (t >= M_CPRI9P8) begin
      push(OP_PMA_REG, REG_EMIB_RESET, ARG_ON, 1'h1);
      push(OP_PMA_REG, REG_EMIB_RESET, ARG_OFF, 1'h1);
    end
    push(OP_ATTR, ATTR_SERDES_EN, ARG_ON, 1'h1);
    push(OP_ATTR, ATTR_LOOPBACK, ARG_ON, 1'h1);
  endfunction : build
  task automatic chk_ops();
    logic [32:0] s;
    chk("op count", exp_q.size(), u_rrs_dev_model.log_q.size());
    foreach (exp_q[i]) begin
      s = '1;
      if (i < u_rrs_dev_model.log_q.size()) s = u_rrs_dev_model.log_q[i];
      if (!exp_q[i][33]) s[7:0] = exp_q[i][7:0];
      cmp_count++;
      if (s !== exp_q[i][32:0]) begin
        fail_count++;
        $display("[FAIL] op %0d expected %h seen %h", i, exp_q[i][32:0], s);
      end
    end
  endtask : chk_ops
  task automatic start(rrs_mode_t t, logic br, logic poke);
    int n;
    u_rrs_dev_model.log_q.delete();
    wr(ADDR_CTRL, {23'h0, br, 3'h0, t, 1'h1});
    for (n = 0; n < 8 && d[0] !== 1'h1; n++) rd(ADDR_STATUS, d);
    // A start while busy must be dropped
    if (poke) wr(ADDR_CTRL, 32'h0000_0001);
    for (n = 0; n < 4000 && d[0] !== 1'h0; n++) rd(ADDR_STATUS, d);
  endtask : start
  initial begin
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    chk("reset outs", 32'h0, {28'h0, tx_n, rx_n, req, gen});
    repeat (2) @(posedge clock);
    rst_b <= 1'h1;
    rd(ADDR_CTRL, d);
    chk("ctrl", 32'h104, d);
    rd(ADDR_PKT_EXPECT, d);
    chk("pkt expect", 32'h46, d);
    rd(8'h0C, d);
    chk("unmapped", 32'h0, d);
    wr(ADDR_PKT_EXPECT, 32'h10);
    wr(ADDR_CTRL, 32'h13);
    rd(ADDR_STATUS, d);
    chk("bad mode", 32'h200, d & 32'hF07);
    foreach (rows[i]) begin
      build(cur, rows[i].to, rows[i].br);
      dly <= rows[i].dly;
      start(rows[i].to, rows[i].br, i == 0);
      chk("done", 32'h2, d & 32'h7);
      chk("mode", {28'h0, rows[i].to}, {28'h0, d[11:8]});
      chk("resets", 32'h3, {30'h0, tx_n, rx_n});
      chk("gen off", 32'h0, {31'h0, gen});
      chk_ops();
      if (rows[i].to <= M_ETH25_STAMP) begin
        chk("link", rows[i].to == M_ETH25_STAMP ? 32'h1F : 32'h07,
          {27'h0, d[20:16]});
        chk("rx pkts", 32'h1, {31'h0, rx_cnt >= 16'h0010});
      end
      cur = rows[i].to;
    end
    // Long idle first; a stale wait count must not fail the next step
    repeat (80) @(posedge clock);
    build(cur, M_ETH25, 1'h1);
    start(M_ETH25, 1'h1, 1'h0);
    chk("idle start", 32'h2, d & 32'h7);
    chk_ops();
    mute <= 1'h1;
    start(M_ETH10, 1'h1, 1'h0);
    chk("timeout", 32'h4, d & 32'h7);
    conclude();
  end
endmodule : test_rrs_sequencer
`default_nettype wire
